// *** core/ippk_pkg.sv ***
/*
  Shared constants and types of the input process image packer.
  Assumes image byte offsets are word indices on a 32-bit Wishbone bus.
*/
package ippk_pkg;

  localparam int unsigned IDX_W      = 9;
  localparam int unsigned NUM_PORTS  = 8;
  localparam int unsigned NUM_IOL    = 3;
  localparam int unsigned REGION_LEN = 32;
  localparam int unsigned MEM_AW     = 7;
  localparam int unsigned MEM_DEPTH  = 96;
  localparam int unsigned MODE_W     = 2;

  typedef logic [IDX_W-1:0]   ippk_idx_t;
  typedef logic [2:0][7:0]    ippk_qual_t;

  // image indices (byte offset of the process image)
  localparam ippk_idx_t DI_LOW_IDX  = 9'h003;
  localparam ippk_idx_t DI_HIGH_IDX = 9'h004;
  localparam ippk_idx_t QUAL_IDX   [NUM_IOL] = '{9'h0AF, 9'h0D1, 9'h0F3};
  localparam ippk_idx_t RSV_IDX    [NUM_IOL] = '{9'h0B0, 9'h0D2, 9'h0F4};
  localparam ippk_idx_t REGION_IDX [NUM_IOL] = '{9'h0B1, 9'h0D3, 9'h0F5};

  // control registers placed above the image
  localparam ippk_idx_t CFG_IDX  = 9'h120;
  localparam ippk_idx_t MODE_IDX = 9'h121;
  localparam ippk_idx_t DIR_IDX  = 9'h122;

  localparam int unsigned CFG_LAYOUT_BIT = 0;
  localparam logic        CFG_RST        = 1'h0;
  localparam logic [5:0]  MODE_RST       = 6'h00;
  localparam logic [15:0] DIR_RST        = 16'h0000;

  typedef enum logic [MODE_W-1:0] {
    MODE_IOLINK,
    MODE_DIN,
    MODE_DOUT
  } ippk_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_FETCH,
    BUS_ANSWER
  } ippk_bus_state_t;

endpackage

// *** core/ippk_mem_if.sv ***
/*
  Carrier between the packer and its image data store.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface ippk_mem_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [2:0] clr;

  modport user
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    output clr,
    input  rd_data
  );

  modport store
  (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    input  clr,
    output rd_data
  );
endinterface

// *** core/ippk_image_mem.sv ***
/*
  Device input data store for the three 32-byte port regions.
  Assumes addresses below the depth; read data is registered.
*/
`timescale 1ns/1ps
module ippk_image_mem
  import ippk_pkg::*;
(
  input wire logic    clk_i,
  input wire logic    rst_i,
  ippk_mem_if.store   mem_if
);

  logic [7:0]           mem_array [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] written_reg;
  logic [MEM_DEPTH-1:0] written_next;
  logic [7:0]           rd_data_reg;
  logic [7:0]           rd_data_next;

  // unwritten bytes read as zero, never as stale or unknown content
  always_comb
  begin
    written_next = written_reg;
    for (int k = 0; k < NUM_IOL; k++)
    begin
      if (mem_if.clr[k])
      begin
        written_next[k*REGION_LEN +: REGION_LEN] = '0;
      end
    end
    if (mem_if.wr_en)
    begin
      written_next[mem_if.wr_addr] = 1'b1;
    end
    rd_data_next = written_reg[mem_if.rd_addr] ? mem_array[mem_if.rd_addr] : 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      written_reg <= '0;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      written_reg <= written_next;
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (mem_if.wr_en)
    begin
      mem_array[mem_if.wr_addr] <= mem_if.wr_data;
    end
  end

  assign mem_if.rd_data = rd_data_reg;

endmodule

// *** core/ippk_pin_sync.sv ***
/*
  Three-stage synchroniser with agreement filter for the port pin levels.
  Assumes asynchronous pin inputs; one clock.
*/
`timescale 1ns/1ps
module ippk_pin_sync
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] raw_i,
  output logic      [15:0] level_o
);

  logic [15:0] s1_reg;
  logic [15:0] s2_reg;
  logic [15:0] s3_reg;
  logic [15:0] level_reg;
  logic [15:0] level_next;

  // first stage feeds only the second
  always_comb
  begin
    level_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level_reg);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg    <= 16'h0000;
      s2_reg    <= 16'h0000;
      s3_reg    <= 16'h0000;
      level_reg <= 16'h0000;
    end
    else
    begin
      s1_reg    <= raw_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule

// *** core/ippk_packer.sv ***
/*
  Input process image packer: qualifier bytes, device data regions of
  ports six to eight and the packed digital bytes, read over Wishbone.
  Assumes a classic Wishbone master, same-clock device data and drive
  levels, and asynchronous pin levels.
*/
// Overview of operation
// - port six qualifier at 175, zero byte at 176
// - port seven qualifier at 209, zero byte at 210
// - port eight qualifier at 243, zero byte at 244
// - port six device input data fills 32 bytes from 177
// - port seven device input data fills 32 bytes from 211
// - port eight device input data fills 32 bytes from 245
// - digital input mode: bit 0 of first byte is input state, rest zero
// - digital output mode: bit 0 of first byte mirrors output, rest zero
// - digital modes: region bytes after the first are reserved
// - port-based or pin-based packing, port-based after reset
// - port-based: pin 4 then pin 2 per port, bytes 3 and 4
// - pin-based: pin 4 bits in byte 3, pin 2 bits in byte 4
// - each packed bit is sensed level or mirrored drive level

`timescale 1ns/1ps
module ippk_packer
  import ippk_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [7:0]        input_channel_a_i,
  input  wire logic [7:0]        input_channel_b_i,
  input  wire logic [7:0]        drive_channel_a_i,
  input  wire logic [7:0]        drive_channel_b_i,
  input  wire ippk_pkg::ippk_qual_t port_qualifier_byte_i,
  input  wire logic              iol_valid_i,
  input  wire logic [1:0]        iol_port_i,
  input  wire logic [4:0]        iol_index_i,
  input  wire logic [7:0]        iol_data_i
);

  ippk_mem_if mem_if ();

  logic [15:0]     sync_level;
  logic [7:0]      sense_a;
  logic [7:0]      sense_b;
  logic [7:0]      chan_a;
  logic [7:0]      chan_b;
  logic [15:0]     pack_port;
  logic [15:0]     pack_pin;
  logic [15:0]     packed_di;

  logic            layout_reg;
  logic            layout_next;
  logic [5:0]      mode_reg;
  logic [5:0]      mode_next;
  logic [15:0]     dir_reg;
  logic [15:0]     dir_next;

  ippk_bus_state_t state_reg;
  ippk_bus_state_t state_next;
  logic [31:0]     dat_reg;
  logic [31:0]     dat_next;
  logic            ack_reg;
  logic            ack_next;

  ippk_idx_t       idx;
  logic            in_range;
  logic            bus_req;
  logic            wr_take;
  logic [2:0]      region_hit;
  logic [4:0]      region_off [NUM_IOL];
  ippk_mode_t      port_mode [NUM_IOL];
  logic [2:0]      port_is_iol;
  logic [7:0]      status_byte [NUM_IOL];
  logic [7:0]      read_byte;
  logic [31:0]     read_word;

  ippk_pin_sync u_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   ({input_channel_b_i, input_channel_a_i}),
    .level_o (sync_level)
  );

  ippk_image_mem u_mem
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .mem_if (mem_if)
  );

  assign sense_a = sync_level[7:0];
  assign sense_b = sync_level[15:8];

  // output pins report what is driven, inputs what is sensed
  assign chan_a = (dir_reg[7:0] & drive_channel_a_i) | (~dir_reg[7:0] & sense_a);
  assign chan_b = (dir_reg[15:8] & drive_channel_b_i) | (~dir_reg[15:8] & sense_b);

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_pack
      assign pack_port[2*p]   = chan_a[p];
      assign pack_port[2*p+1] = chan_b[p];
    end
  endgenerate

  assign pack_pin  = {chan_b, chan_a};
  assign packed_di = layout_reg ? pack_pin : pack_port;

  // per-port pin 4 mode of ports six to eight
  always_comb
  begin
    for (int k = 0; k < NUM_IOL; k++)
    begin
      port_mode[k]   = ippk_mode_t'(mode_reg[k*MODE_W +: MODE_W]);
      port_is_iol[k] = (port_mode[k] == MODE_IOLINK);
      status_byte[k] = 8'h00;
      unique case (port_mode[k])
        MODE_IOLINK:
        begin
          status_byte[k] = 8'h00;
        end
        MODE_DIN:
        begin
          status_byte[k] = {7'h00, sense_a[5+k]};
        end
        MODE_DOUT:
        begin
          status_byte[k] = {7'h00, drive_channel_a_i[5+k]};
        end
        default:
        begin
          status_byte[k] = 8'h00;
        end
      endcase
    end
  end

  // device data is accepted only for a port that runs IO-Link
  assign mem_if.wr_en   = iol_valid_i && (iol_port_i < 2'h3) &&
                          port_is_iol[iol_port_i];
  assign mem_if.wr_addr = {iol_port_i, iol_index_i};
  assign mem_if.wr_data = iol_data_i;
  assign mem_if.clr     = ~port_is_iol;

  assign idx      = wb_adr_i[10:2];
  assign in_range = (wb_adr_i[31:11] == 21'h000000);
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign wr_take  = ack_reg && bus_req && wb_we_i && in_range;

  // region decode; address is held by the master, so read is issued early
  always_comb
  begin
    region_hit     = 3'h0;
    mem_if.rd_addr = 7'h00;
    for (int k = 0; k < NUM_IOL; k++)
    begin
      region_off[k] = 5'(idx - REGION_IDX[k]);
      region_hit[k] = in_range && (idx >= REGION_IDX[k]) &&
                      ({1'b0, idx} < {1'b0, REGION_IDX[k]} + 10'(REGION_LEN));
      if (region_hit[k])
      begin
        mem_if.rd_addr = {2'(k), region_off[k]};
      end
    end
  end

  always_comb
  begin
    read_byte = 8'h00;
    read_word = 32'h00000000;
    if (in_range)
    begin
      if (idx == DI_LOW_IDX)
      begin
        read_byte = packed_di[7:0];
      end
      else if (idx == DI_HIGH_IDX)
      begin
        read_byte = packed_di[15:8];
      end
      for (int k = 0; k < NUM_IOL; k++)
      begin
        if (idx == QUAL_IDX[k])
        begin
          read_byte = port_qualifier_byte_i[k];
        end
        else if (idx == RSV_IDX[k])
        begin
          read_byte = 8'h00;
        end
        else if (region_hit[k])
        begin
          if (port_is_iol[k])
          begin
            read_byte = mem_if.rd_data;
          end
          else if (region_off[k] == 5'h00)
          begin
            read_byte = status_byte[k];
          end
          else
          begin
            read_byte = 8'h00;
          end
        end
      end
      read_word = {24'h000000, read_byte};
      if (idx == CFG_IDX)
      begin
        read_word = {31'h00000000, layout_reg};
      end
      else if (idx == MODE_IDX)
      begin
        read_word = {26'h0000000, mode_reg};
      end
      else if (idx == DIR_IDX)
      begin
        read_word = {16'h0000, dir_reg};
      end
    end
  end

  // control registers change at the edge where the master samples ack
  always_comb
  begin
    layout_next = layout_reg;
    mode_next   = mode_reg;
    dir_next    = dir_reg;
    if (wr_take && wb_sel_i[0])
    begin
      if (idx == CFG_IDX)
      begin
        layout_next = wb_dat_i[CFG_LAYOUT_BIT];
      end
      else if (idx == MODE_IDX)
      begin
        mode_next = wb_dat_i[5:0];
      end
      else if (idx == DIR_IDX)
      begin
        dir_next[7:0] = wb_dat_i[7:0];
      end
    end
    if (wr_take && wb_sel_i[1] && (idx == DIR_IDX))
    begin
      dir_next[15:8] = wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      layout_reg <= CFG_RST;
      mode_reg   <= MODE_RST;
      dir_reg    <= DIR_RST;
    end
    else
    begin
      layout_reg <= layout_next;
      mode_reg   <= mode_next;
      dir_reg    <= dir_next;
    end
  end

  // fixed two-cycle answer gives the store time for its registered read
  always_comb
  begin
    state_next = state_reg;
    dat_next   = dat_reg;
    ack_next   = 1'b0;
    unique case (state_reg)
      BUS_IDLE:
      begin
        if (bus_req)
        begin
          state_next = BUS_FETCH;
        end
      end
      BUS_FETCH:
      begin
        if (bus_req)
        begin
          dat_next   = wb_we_i ? 32'h00000000 : read_word;
          ack_next   = 1'b1;
          state_next = BUS_ANSWER;
        end
        else
        begin
          state_next = BUS_IDLE;
        end
      end
      BUS_ANSWER:
      begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= BUS_IDLE;
      dat_reg   <= 32'h00000000;
      ack_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      dat_reg   <= dat_next;
      ack_reg   <= ack_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

endmodule

// *** sim/ippk_packer_sva.sv ***
/*
  Bus timing and image map checks of the packer, bound to its top ports.
  Assumes pin, drive and qualifier inputs are held still around reads.
*/
`timescale 1ns/1ps
module ippk_packer_chk
  import ippk_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [31:0]          wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [7:0]           drive_channel_a_i,
  input wire ippk_pkg::ippk_qual_t port_qualifier_byte_i
);
  logic [8:0] idx;
  logic       rd_ok;
  logic       wr_ok;
  logic       in_rgn;
  logic [1:0] rj;
  logic [5:0] ro;
  logic [1:0] mf;
  logic       cfg_reg;
  logic       cfg_next;
  logic [5:0] mode_reg;
  logic [5:0] mode_next;

  // mirrors of the control writes, so map checks know the current mode
  always_comb
  begin
    idx       = wb_adr_i[10:2];
    rd_ok     = wb_ack_o && !wb_we_i && wb_adr_i[31:11] == 21'h0;
    wr_ok     = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[31:11] == 21'h0;
    rj        = 2'((idx - 9'h0B1) / 9'h022);
    ro        = 6'((idx - 9'h0B1) % 9'h022);
    in_rgn    = idx >= 9'h0B1 && idx <= 9'h114 && ro < 6'h20;
    mf        = 2'(mode_reg >> {rj, 1'b0});
    cfg_next  = (wr_ok && idx == 9'h120) ? wb_dat_i[0] : cfg_reg;
    mode_next = (wr_ok && idx == 9'h121) ? wb_dat_i[5:0] : mode_reg;
  end

  always_ff @(posedge clk_i)
  begin
    cfg_reg  <= rst_i ? 1'h0 : cfg_next;
    mode_reg <= rst_i ? 6'h00 : mode_next;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_delay: assert property (wb_cyc_i && wb_stb_i && !$past(wb_cyc_i && wb_stb_i)
    |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack not two cycles after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
    else $error("ack without request");
  a_qual_map: assert property (rd_ok && (idx == 9'h0AF || idx == 9'h0D1 || idx == 9'h0F3)
    |-> wb_dat_o == {24'h0, port_qualifier_byte_i[(idx - 9'h0AF) / 9'h022]})
    else $error("qualifier byte misplaced");
  a_dummy_zero: assert property (rd_ok && (idx == 9'h0B0 || idx == 9'h0D2 || idx == 9'h0F4)
    |-> wb_dat_o == 32'h0) else $error("dummy byte not zero");
  a_word_upper: assert property (rd_ok && idx < 9'h120 |-> wb_dat_o[31:8] == 24'h0)
    else $error("image word upper bits set");
  a_dout_mirror: assert property (rd_ok && in_rgn && ro == 6'h0 && mf == 2'h2
    |-> wb_dat_o == {31'h0, drive_channel_a_i[rj + 3'h5]}) else $error("output mirror wrong");
  a_din_bits: assert property (rd_ok && in_rgn && ro == 6'h0 && mf == 2'h1
    |-> wb_dat_o[31:1] == 31'h0) else $error("input status upper bits set");
  a_dig_rsv: assert property (rd_ok && in_rgn && ro != 6'h0 && (mf == 2'h1 || mf == 2'h2)
    |-> wb_dat_o == 32'h0) else $error("reserved region byte not zero");

  c_region: cover property (rd_ok && in_rgn && mf == 2'h2);
  c_mode_wr: cover property (wr_ok && idx == 9'h121);
  c_pin_lay: cover property (rd_ok && idx == 9'h003 && cfg_reg);
endmodule

bind ippk_packer ippk_packer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .drive_channel_a_i(drive_channel_a_i), .port_qualifier_byte_i(port_qualifier_byte_i));

// *** sim/ippk_fb_master.sv ***
/*
  Fieldbus-side reader: a classic Wishbone master driven by one task.
  Assumes the slave answers within the task's bound; caller counts misses.
*/
`timescale 1ns/1ps
module ippk_fb_master
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [31:0] adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 32'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  task automatic xfer(input logic w, input logic [8:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdat, output bit ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {21'h0, idx, 2'h0};
    sel_o <= 4'hF;
    dat_o <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 64);
    ok = (ack_i === 1'b1);
    rdat = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released write data flips so no stale word is mistaken for a request
    dat_o <= ~wd;
  endtask
endmodule

// *** sim/tb_top.sv ***
/*
  Bench of the packer: image map, device data, digital modes, packing.
  Assumes a 250 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import ippk_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  sel;
  logic [7:0]  in_a = 8'h00, in_b = 8'h00, drv_a = 8'h00, drv_b = 8'h00;
  logic        iv = 1'b0;
  logic [1:0]  ip = 2'h0;
  logic [4:0]  ii = 5'h00;
  logic [7:0]  id = 8'h00;
  ippk_qual_t  qual = 24'hC3965A;
  logic [15:0] dirs [3] = '{16'h0000, 16'hFFFF, 16'h33C5};
  int          errors = 0;
  int          checked = 0;

  always #2 clk = ~clk;

  ippk_fb_master u_fb (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  ippk_packer dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .input_channel_a_i(in_a), .input_channel_b_i(in_b), .drive_channel_a_i(drv_a),
    .drive_channel_b_i(drv_b), .port_qualifier_byte_i(qual), .iol_valid_i(iv),
    .iol_port_i(ip), .iol_index_i(ii), .iol_data_i(id));

  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rw(input logic w, input logic [8:0] idx, input logic [31:0] wd,
                    output logic [31:0] d);
    bit ok;
    u_fb.xfer(w, idx, wd, d, ok);
    if (!ok)
    begin
      errors++;
      $display("[ERR] %0t no bus answer", $time);
      end_of_test();
    end
  endtask

  task automatic rd(input logic [8:0] idx, input logic [31:0] e);
    logic [31:0] d;
    rw(1'b0, idx, 32'h0, d);
    `CHK(d, e)
  endtask

  task automatic wr(input logic [8:0] idx, input logic [31:0] v);
    logic [31:0] d;
    rw(1'b1, idx, v, d);
  endtask

  // expected packed pair: byte 3 in bits 7:0, byte 4 in bits 15:8
  function automatic logic [15:0] pack(input logic lay, input logic [15:0] dir);
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] p;
    a = (dir[7:0] & drv_a) | (~dir[7:0] & in_a);
    b = (dir[15:8] & drv_b) | (~dir[15:8] & in_b);
    for (int n = 0; n < 8; n++)
      p[2*n +: 2] = {b[n], a[n]};
    return lay ? {b, a} : p;
  endfunction

  initial
  begin
    logic [15:0] e;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 3; j++)
    begin
      rd(9'(175 + 34 * j), {24'h0, qual[j]});
      rd(9'(176 + 34 * j), 32'h0);
      rd(9'(177 + 34 * j), 32'h0);
    end
    rd(9'h120, 32'h0);
    wr(9'h0AF, 32'hFF);
    rd(9'h0AF, {24'h0, qual[0]});
    rd(9'h115, 32'h0);
    $display("test map done");
    for (int k = 0; k < 97; k++)
    begin
      @(posedge clk);
      iv <= 1'b1;
      ip <= (k == 96) ? 2'h3 : 2'(k / 32);
      ii <= 5'(k);
      id <= (k == 96) ? 8'h00 : {1'b1, 2'(k / 32), 5'(k)};
    end
    @(posedge clk);
    iv <= 1'b0;
    for (int k = 0; k < 96; k++)
      rd(9'(177 + 34 * (k / 32) + k % 32), {24'h0, 1'b1, 2'(k / 32), 5'(k)});
    $display("test device data done");
    for (int v = 0; v < 2; v++)
    begin
      in_a <= {8{~v[0]}};
      drv_a <= {8{v[0]}};
      wr(9'h121, v ? 32'h16 : 32'h09);
      repeat (8) @(posedge clk);
      rd(9'h0B1, 32'h1);
      rd(9'h0D3, 32'h0);
      rd(9'h0D0, 32'h0);
      rd(9'h0D4, 32'h0);
      rd(9'h0F5, v ? 32'h0 : 32'hC0);
    end
    wr(9'h121, 32'h3F);
    rd(9'h0B1, 32'h0);
    // a byte for a port outside IO-Link mode must be dropped
    @(posedge clk);
    iv <= 1'b1;
    ip <= 2'h0;
    id <= 8'h55;
    @(posedge clk);
    iv <= 1'b0;
    wr(9'h121, 32'h0);
    rd(9'h0B1, 32'h0);
    $display("test modes done");
    in_a <= 8'h3C;
    in_b <= 8'h96;
    drv_a <= 8'hF0;
    drv_b <= 8'h0F;
    for (int k = 0; k < 6; k++)
    begin
      if (k != 0)
      begin
        wr(9'h120, 32'(k / 3));
        wr(9'h122, {16'h0, dirs[k % 3]});
      end
      repeat (8) @(posedge clk);
      e = pack(k / 3, dirs[k % 3]);
      rd(9'h003, {24'h0, e[7:0]});
      rd(9'h004, {24'h0, e[15:8]});
    end
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    e = pack(1'b0, 16'h0);
    rd(9'h003, {24'h0, e[7:0]});
    $display("test packing done");
    end_of_test();
  end
endmodule
